// file: logic/rtc_regs.svh
// Register indices, field positions, reset values and counts of the real-time clock core.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

`define RTC_IDX_RUN      4'h0
`define RTC_IDX_IRQ      4'h1
`define RTC_IDX_SEC      4'h2
`define RTC_IDX_MIN      4'h3
`define RTC_IDX_HOUR     4'h4
`define RTC_IDX_DAY      4'h5
`define RTC_IDX_WDAY     4'h6
`define RTC_IDX_MON      4'h7
`define RTC_IDX_YEAR     4'h8
`define RTC_IDX_AL_MIN   4'h9
`define RTC_IDX_AL_HOUR  4'ha
`define RTC_IDX_AL_DAY   4'hb
`define RTC_IDX_AL_WDAY  4'hc
`define RTC_IDX_CLKSEL   4'hd
`define RTC_IDX_CD_CTL   4'he
`define RTC_IDX_CD_VAL   4'hf

`define RTC_BIT_HALT     5
`define RTC_BIT_REPEAT   4
`define RTC_BIT_AF       3
`define RTC_BIT_TF       2
`define RTC_BIT_AIE      1
`define RTC_BIT_TIE      0
`define RTC_BIT_LV       7
`define RTC_BIT_AE       7
`define RTC_BIT_CDEN     7

`define RTC_LV_RESET     1'b1
`define RTC_FSEL_RESET   2'h0
`define RTC_HALT_RESET   1'b0

`define RTC_PRESC_W      15
`define RTC_HALF_SEC     15'h4000
`define RTC_T4096_MASK   15'h0007
`define RTC_T64_MASK     15'h01ff
`define RTC_TAP_1024     4
`define RTC_TAP_32       9
`define RTC_TAP_1        14

`endif

// file: logic/rtc_pkg.sv
// Types shared by the real-time clock core and its crystal prescaler.
package rtc_pkg;

  typedef enum logic [1:0] {
    RTC_SRC_4096,
    RTC_SRC_64,
    RTC_SRC_1,
    RTC_SRC_MIN
  } rtc_src_e;

  typedef struct packed {
    logic        xtal_lvl;
    logic        tick_4096;
    logic        tick_64;
    logic        tick_sec;
    logic [14:0] presc;
  } rtc_tick_s;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [5:0] day;
    logic [2:0] wday;
    logic [4:0] mon;
    logic [7:0] year;
  } rtc_time_s;

endpackage

// file: logic/rtc_prescale.sv
// Crystal input synchroniser and divider producing the sub-second ticks.
`include "rtc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtc_prescale #(
  parameter logic [`RTC_PRESC_W-1:0] HALF_SEC_COUNT = `RTC_HALF_SEC
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              xtal_in,
  input  wire logic              halt,
  output rtc_pkg::rtc_tick_s     tick
);

  logic                    sync1_reg;
  logic                    sync2_reg;
  logic                    prev_reg;
  logic [`RTC_PRESC_W-1:0] presc_reg;
  logic [`RTC_PRESC_W-1:0] presc_next;
  logic                    rise;

  // The divider is held at zero while halted, so the first second after release takes half a
  // crystal period count and every later one a full period.
  always_comb begin
    rise       = sync2_reg & ~prev_reg;
    presc_next = presc_reg;
    if (halt) begin
      presc_next = '0;
    end else if (rise) begin
      presc_next = presc_reg + 15'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      presc_reg <= '0;
      tick      <= '0;
    end else begin
      sync1_reg          <= xtal_in;
      sync2_reg          <= sync1_reg;
      prev_reg           <= sync2_reg;
      presc_reg          <= presc_next;
      tick.xtal_lvl      <= sync2_reg;
      tick.presc         <= presc_next;
      tick.tick_4096     <= rise & ~halt & ((presc_next & `RTC_T4096_MASK) == '0);
      tick.tick_64       <= rise & ~halt & ((presc_next & `RTC_T64_MASK) == '0);
      tick.tick_sec      <= rise & ~halt & (presc_next == HALF_SEC_COUNT);
    end
  end

endmodule // rtc_prescale
`default_nettype wire

// file: logic/rtc_core.sv
// Real-time clock core: calendar, countdown timer, alarm and clock output behind Avalon-MM.
//
// Contract
// - Seconds to year counters, settable, readable, carrying.
// - Years divisible by four get February 29.
// - Countdown period from 244.14 us to 255 minutes.
// - Timer event sets flag, pulls interrupt if enabled.
// - Level or repeated pulse interrupt for timer.
// - Enabled alarm fields matching set flag, interrupt.
// - Open-drain clock output carries 32.768 kHz.
// - Two-bit select: 32.768k, 1024, 32, 1 Hz.
// - Power-up sets the low-voltage flag.
// - Power-up clears clock output frequency select.
// - Enable pin high presents selected frequency.
// - Unused bits written zero, masked on read.
// - Counters hold packed BCD values.
// - Any seconds write clears low-voltage flag.
// - Repeat select one repeated pulse, zero level interrupt.
// - Halt freezes all but the 32.768 kHz clock output; resume advances after 0.5 s.
`include "rtc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtc_core #(parameter logic [`RTC_PRESC_W-1:0] HALF_SEC_COUNT = `RTC_HALF_SEC) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        xtal_in,
  input  wire logic        clock_output_enable_pin,
  output logic             clock_output_pin_out,
  output logic             clock_output_pin_oe,
  output logic             irq_n_out,
  output logic             irq_n_oe
);

  // ------------------------------------------------------------------
  // BCD helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Last day of a month in BCD, leap years being those whose two digits divide by four.
  function automatic logic [7:0] month_len(input logic [4:0] mon, input logic [7:0] yr);
    logic [3:0] mod_sum;
    logic [7:0] r;
    mod_sum = yr[3:0] + {2'h0, yr[4], 1'b0};
    r = 8'h31;
    if (mon == 5'h02) begin
      r = (mod_sum[1:0] == 2'h0) ? 8'h29 : 8'h28;
    end else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
      r = 8'h30;
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  rtc_pkg::rtc_tick_s  tick;
  rtc_pkg::rtc_time_s  tm_reg;
  rtc_pkg::rtc_time_s  tm_next;
  logic                halt_reg;
  logic                halt_next;
  logic                repeat_reg;
  logic                repeat_next;
  logic                af_reg;
  logic                af_next;
  logic                tf_reg;
  logic                tf_next;
  logic                aie_reg;
  logic                aie_next;
  logic                tie_reg;
  logic                tie_next;
  logic                lv_reg;
  logic                lv_next;
  logic [7:0]          al_reg [4];
  logic [7:0]          al_next [4];
  logic [1:0]          fsel_reg;
  logic [1:0]          fsel_next;
  logic                cden_reg;
  logic                cden_next;
  rtc_pkg::rtc_src_e   src_reg;
  rtc_pkg::rtc_src_e   src_next;
  logic [7:0]          cdval_reg;
  logic [7:0]          cdval_next;
  logic [7:0]          cdcnt_reg;
  logic [7:0]          cdcnt_next;
  logic                pulse_reg;
  logic                pulse_next;
  logic                match_prev_reg;
  logic                match_prev_next;
  logic                ack_reg;
  logic                ack_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic                ce1_reg;
  logic                ce2_reg;
  logic                clock_output_pin_lvl_reg;
  logic                clock_output_pin_lvl_next;

  logic                req;
  logic                wr_en;
  logic [3:0]          idx;
  logic [7:0]          wd;
  logic                min_tick;
  logic                src_tick;
  logic                cd_event;
  logic                match;

  rtc_prescale #(.HALF_SEC_COUNT(HALF_SEC_COUNT)) u_prescale (
    .clk     (clk),
    .rstn    (rstn),
    .xtal_in (xtal_in),
    .halt    (halt_reg),
    .tick    (tick)
  );

  // ------------------------------------------------------------------
  // Bus slave: one wait state, write and read data at the edge with waitrequest low
  // ------------------------------------------------------------------
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign idx             = avs_address[5:2];
  assign wd              = avs_writedata[7:0];
  assign wr_en           = avs_write & ack_reg & avs_byteenable[0];

  always_comb begin
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg) begin
      rdata_next = '0;
      unique case (idx)
        `RTC_IDX_RUN:     rdata_next[`RTC_BIT_HALT] = halt_reg;
        `RTC_IDX_IRQ:     rdata_next[4:0] = {repeat_reg, af_reg, tf_reg, aie_reg, tie_reg};
        `RTC_IDX_SEC:     rdata_next[7:0] = {lv_reg, tm_reg.sec};
        `RTC_IDX_MIN:     rdata_next[6:0] = tm_reg.min;
        `RTC_IDX_HOUR:    rdata_next[5:0] = tm_reg.hour;
        `RTC_IDX_DAY:     rdata_next[5:0] = tm_reg.day;
        `RTC_IDX_WDAY:    rdata_next[2:0] = tm_reg.wday;
        `RTC_IDX_MON:     rdata_next[4:0] = tm_reg.mon;
        `RTC_IDX_YEAR:    rdata_next[7:0] = tm_reg.year;
        `RTC_IDX_AL_MIN:  rdata_next[7:0] = al_reg[0];
        `RTC_IDX_AL_HOUR: rdata_next[7:0] = al_reg[1];
        `RTC_IDX_AL_DAY:  rdata_next[7:0] = al_reg[2];
        `RTC_IDX_AL_WDAY: rdata_next[7:0] = al_reg[3];
        `RTC_IDX_CLKSEL:  rdata_next[1:0] = fsel_reg;
        `RTC_IDX_CD_CTL:  rdata_next[7:0] = {cden_reg, 5'h00, src_reg};
        `RTC_IDX_CD_VAL:  rdata_next[7:0] = cdval_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Calendar counters
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0] t;
    t        = '0;
    tm_next  = tm_reg;
    min_tick = 1'b0;
    if (tick.tick_sec) begin
      t = bcd_inc({1'b0, tm_reg.sec});
      tm_next.sec = t[6:0];
      if (tm_reg.sec == 7'h59) begin
        tm_next.sec = 7'h00;
        min_tick    = 1'b1;
        t = bcd_inc({1'b0, tm_reg.min});
        tm_next.min = t[6:0];
        if (tm_reg.min == 7'h59) begin
          tm_next.min = 7'h00;
          t = bcd_inc({2'h0, tm_reg.hour});
          tm_next.hour = t[5:0];
          if (tm_reg.hour == 6'h23) begin
            tm_next.hour = 6'h00;
            tm_next.wday = (tm_reg.wday >= 3'h6) ? 3'h0 : tm_reg.wday + 3'h1;
            t = bcd_inc({2'h0, tm_reg.day});
            tm_next.day = t[5:0];
            if ({2'h0, tm_reg.day} >= month_len(tm_reg.mon, tm_reg.year)) begin
              tm_next.day = 6'h01;
              t = bcd_inc({3'h0, tm_reg.mon});
              tm_next.mon = t[4:0];
              if (tm_reg.mon >= 5'h12) begin
                tm_next.mon  = 5'h01;
                tm_next.year = (tm_reg.year == 8'h99) ? 8'h00 : bcd_inc(tm_reg.year);
              end
            end
          end
        end
      end
    end
    if (wr_en) begin
      unique case (idx)
        `RTC_IDX_SEC:  tm_next.sec  = wd[6:0];
        `RTC_IDX_MIN:  tm_next.min  = wd[6:0];
        `RTC_IDX_HOUR: tm_next.hour = wd[5:0];
        `RTC_IDX_DAY:  tm_next.day  = wd[5:0];
        `RTC_IDX_WDAY: tm_next.wday = wd[2:0];
        `RTC_IDX_MON:  tm_next.mon  = wd[4:0];
        `RTC_IDX_YEAR: tm_next.year = wd;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Control, countdown timer and alarm
  // ------------------------------------------------------------------
  always_comb begin
    match = ~(al_reg[0][`RTC_BIT_AE] & al_reg[1][`RTC_BIT_AE] &
              al_reg[2][`RTC_BIT_AE] & al_reg[3][`RTC_BIT_AE]) &
            (al_reg[0][`RTC_BIT_AE] | (al_reg[0][6:0] == tm_reg.min)) &
            (al_reg[1][`RTC_BIT_AE] | (al_reg[1][5:0] == tm_reg.hour)) &
            (al_reg[2][`RTC_BIT_AE] | (al_reg[2][5:0] == tm_reg.day)) &
            (al_reg[3][`RTC_BIT_AE] | (al_reg[3][2:0] == tm_reg.wday));
    unique case (src_reg)
      rtc_pkg::RTC_SRC_4096: src_tick = tick.tick_4096;
      rtc_pkg::RTC_SRC_64:   src_tick = tick.tick_64;
      rtc_pkg::RTC_SRC_1:    src_tick = tick.tick_sec;
      rtc_pkg::RTC_SRC_MIN:  src_tick = min_tick;
    endcase
    cd_event        = 1'b0;
    halt_next       = halt_reg;
    repeat_next     = repeat_reg;
    aie_next        = aie_reg;
    tie_next        = tie_reg;
    af_next         = af_reg;
    tf_next         = tf_reg;
    lv_next         = lv_reg;
    al_next         = al_reg;
    fsel_next       = fsel_reg;
    cden_next       = cden_reg;
    src_next        = src_reg;
    cdval_next      = cdval_reg;
    cdcnt_next      = cdcnt_reg;
    pulse_next      = pulse_reg & ~tick.tick_4096;
    match_prev_next = halt_reg ? match_prev_reg : match;
    if (!cden_reg) begin
      cdcnt_next = cdval_reg;
    end else if (src_tick && cdval_reg != 8'h00) begin
      if (cdcnt_reg <= 8'h01) begin
        cd_event   = 1'b1;
        cdcnt_next = cdval_reg;
      end else begin
        cdcnt_next = cdcnt_reg - 8'h01;
      end
    end
    if (wr_en) begin
      unique case (idx)
        `RTC_IDX_RUN: halt_next = wd[`RTC_BIT_HALT];
        `RTC_IDX_IRQ: begin
          repeat_next = wd[`RTC_BIT_REPEAT];
          aie_next    = wd[`RTC_BIT_AIE];
          tie_next    = wd[`RTC_BIT_TIE];
          af_next     = af_reg & wd[`RTC_BIT_AF];
          tf_next     = tf_reg & wd[`RTC_BIT_TF];
        end
        `RTC_IDX_SEC:     lv_next = 1'b0;
        `RTC_IDX_AL_MIN:  al_next[0] = wd;
        `RTC_IDX_AL_HOUR: al_next[1] = {wd[7], 1'b0, wd[5:0]};
        `RTC_IDX_AL_DAY:  al_next[2] = {wd[7], 1'b0, wd[5:0]};
        `RTC_IDX_AL_WDAY: al_next[3] = {wd[7], 4'h0, wd[2:0]};
        `RTC_IDX_CLKSEL:  fsel_next = wd[1:0];
        `RTC_IDX_CD_CTL: begin
          cden_next = wd[`RTC_BIT_CDEN];
          src_next  = rtc_pkg::rtc_src_e'(wd[1:0]);
        end
        `RTC_IDX_CD_VAL: begin
          cdval_next = wd;
          cdcnt_next = wd;
        end
        default: ;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle.
    if (cd_event) begin
      tf_next    = 1'b1;
      pulse_next = 1'b1;
    end
    if (match && !match_prev_reg && !halt_reg) begin
      af_next = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Output pins
  // ------------------------------------------------------------------
  always_comb begin
    unique case (fsel_reg)
      2'h0:    clock_output_pin_lvl_next = tick.xtal_lvl;
      2'h1:    clock_output_pin_lvl_next = tick.presc[`RTC_TAP_1024] & ~halt_reg;
      2'h2:    clock_output_pin_lvl_next = tick.presc[`RTC_TAP_32] & ~halt_reg;
      default: clock_output_pin_lvl_next = tick.presc[`RTC_TAP_1] & ~halt_reg;
    endcase
  end

  // The pin only ever sinks; a high level comes from the external pull-up.
  assign clock_output_pin_out = 1'b0;
  assign clock_output_pin_oe  = ce2_reg & ~clock_output_pin_lvl_reg;
  assign irq_n_out            = 1'b0;
  assign irq_n_oe             = (af_reg & aie_reg) |
                                (tie_reg & (repeat_reg ? pulse_reg : tf_reg));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tm_reg         <= '0;
      halt_reg       <= `RTC_HALT_RESET;
      repeat_reg     <= 1'b0;
      af_reg         <= 1'b0;
      tf_reg         <= 1'b0;
      aie_reg        <= 1'b0;
      tie_reg        <= 1'b0;
      lv_reg         <= `RTC_LV_RESET;
      al_reg         <= '{default: 8'h80};
      fsel_reg       <= `RTC_FSEL_RESET;
      cden_reg       <= 1'b0;
      src_reg        <= rtc_pkg::RTC_SRC_4096;
      cdval_reg      <= 8'h00;
      cdcnt_reg      <= 8'h00;
      pulse_reg      <= 1'b0;
      match_prev_reg <= 1'b0;
      ack_reg        <= 1'b0;
      rdata_reg      <= '0;
      ce1_reg        <= 1'b0;
      ce2_reg        <= 1'b0;
      clock_output_pin_lvl_reg <= 1'b0;
    end else begin
      tm_reg         <= tm_next;
      halt_reg       <= halt_next;
      repeat_reg     <= repeat_next;
      af_reg         <= af_next;
      tf_reg         <= tf_next;
      aie_reg        <= aie_next;
      tie_reg        <= tie_next;
      lv_reg         <= lv_next;
      al_reg         <= al_next;
      fsel_reg       <= fsel_next;
      cden_reg       <= cden_next;
      src_reg        <= src_next;
      cdval_reg      <= cdval_next;
      cdcnt_reg      <= cdcnt_next;
      pulse_reg      <= pulse_next;
      match_prev_reg <= match_prev_next;
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
      ce1_reg        <= clock_output_enable_pin;
      ce2_reg        <= ce1_reg;
      clock_output_pin_lvl_reg <= clock_output_pin_lvl_next;
    end
  end

endmodule // rtc_core
`default_nettype wire

// file: sim/rtc_board_model.sv
// Board around the clock core: free-running crystal and pull-ups on the open-drain pins.
`timescale 1ns/1ps
`default_nettype none
module rtc_board_model (
  input  wire logic clock_output_pin_out,
  input  wire logic clock_output_pin_oe,
  input  wire logic irq_n_out,
  input  wire logic irq_n_oe,
  output logic      xtal_in,
  output logic      clock_output_pin,
  output logic      irq_n
);
  // The crystal is offset so that its edges never meet the core clock edges.
  initial begin
    xtal_in = 1'b0;
    #3.3;
    forever #40 xtal_in = ~xtal_in;
  end
  // A released open-drain line rests high on its pull-up.
  assign clock_output_pin = clock_output_pin_oe ? clock_output_pin_out : 1'b1;
  assign irq_n = irq_n_oe ? irq_n_out : 1'b1;
endmodule // rtc_board_model
`default_nettype wire

// file: sim/rtc_core_properties.sv
// Port-level checks of the real-time clock core.
`timescale 1ns/1ps
`default_nettype none
module rtc_core_properties (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        xtal_in,
  input wire logic        clock_output_enable_pin,
  input wire logic        clock_output_pin_out,
  input wire logic        clock_output_pin_oe,
  input wire logic        irq_n_out,
  input wire logic        irq_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire req = avs_read || avs_write;
  wire clr = avs_write && avs_byteenable[0] && avs_address[5:2] == 4'h1;
  a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised without a request");
  a_wait_first: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait state");
  a_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_read_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_drain_only: assert property (!clock_output_pin_out && !irq_n_out)
    else $error("open-drain pin driven high");
  a_clock_output_pin_gate: assert property (!clock_output_enable_pin [*5] |-> !clock_output_pin_oe)
    else $error("clock output active while disabled");
  a_reset_quiet: assert property ($rose(rstn) |-> !irq_n_oe && !clock_output_pin_oe)
    else $error("pins active right after reset");
  a_irq_clear: assert property (clr && !avs_waitrequest && avs_writedata[7:0] == 8'h00
    |-> ##[1:3] !irq_n_oe) else $error("interrupt kept after clearing");
  c_write_done: cover property (avs_write && !avs_waitrequest);
  c_irq_rise: cover property ($rose(irq_n_oe));
  c_clock_output_pin_rise: cover property ($rose(clock_output_pin_oe));
endmodule // rtc_core_properties
bind rtc_core rtc_core_properties chk_u (.clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .xtal_in(xtal_in),
  .clock_output_enable_pin(clock_output_enable_pin),
  .clock_output_pin_out(clock_output_pin_out), .clock_output_pin_oe(clock_output_pin_oe),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
`default_nettype wire

// file: sim/tb_rtc_calendar_timer_alarm.sv
// Self-checking testbench of the real-time clock core.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_calendar_timer_alarm;
  logic        clk;
  logic        rstn;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        xtal_in;
  logic        clock_output_enable_pin;
  logic        pin_out;
  logic        pin_oe;
  logic        irq_out;
  logic        irq_oe;
  logic        clock_output_pin;
  logic        irq_n;
  logic [7:0]  rd_data;
  logic        pin_q = 1'b1;
  logic        irq_q = 1'b1;
  int          pin_changes = 0;
  int          irq_falls = 0;
  int          fail_count = 0;
  int          comparisons = 0;
  logic [3:0]  cfg [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'hc, 4'hd};
  int          exp_n [7] = '{256, 8, 0, 0, 0, 256, 0};
  logic [7:0]  tv [7] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h24};
  logic [7:0]  te [7] = '{8'h00, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h24};

  // A short first half second keeps the resume check inside a short run.
  rtc_core #(.HALF_SEC_COUNT(15'h0100)) dut_u (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xtal_in(xtal_in),
    .clock_output_enable_pin(clock_output_enable_pin), .clock_output_pin_out(pin_out),
    .clock_output_pin_oe(pin_oe), .irq_n_out(irq_out), .irq_n_oe(irq_oe));
  rtc_board_model board_u (.clock_output_pin_out(pin_out), .clock_output_pin_oe(pin_oe),
    .irq_n_out(irq_out), .irq_n_oe(irq_oe), .xtal_in(xtal_in),
    .clock_output_pin(clock_output_pin), .irq_n(irq_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    pin_q <= clock_output_pin;
    irq_q <= irq_n;
    if (pin_q !== clock_output_pin) pin_changes <= pin_changes + 1;
    if (irq_q === 1'b1 && irq_n === 1'b0) irq_falls <= irq_falls + 1;
  end

  // ------------------------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    comparisons++;
    if (got > exp + tol || got < exp - tol) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until the edge that sees waitrequest low.
  task automatic bus_go(input logic [3:0] idx, input logic wr, input logic [7:0] d,
                        input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rd_data = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
    if (n >= 64) begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus_go(idx, 1'b1, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    bus_go(idx, 1'b0, 8'h00, 4'h1);
    check(rd_data, exp);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int n;
    int n0;
    rstn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    clock_output_enable_pin = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus_go(4'h2, 1'b0, 8'h00, 4'h1);
    check({rd_data[7], 7'h00}, 8'h80);
    rd_chk(4'hd, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, {2'b00, cfg[i][3], 5'h00});
      wr(4'hd, {6'h00, cfg[i][1:0]});
      clock_output_enable_pin <= cfg[i][2];
      repeat (16) @(posedge clk);
      n0 = pin_changes;
      repeat (1024) @(posedge clk);
      near(pin_changes - n0, exp_n[i], 2);
    end
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h01);
    wr(4'hf, 8'h03);
    wr(4'he, 8'h80);
    n = 0;
    while (irq_n !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    near(n, 200, 200);
    repeat (300) @(posedge clk);
    check({7'h00, irq_n}, 8'h00);
    rd_chk(4'h1, 8'h05);
    wr(4'he, 8'h00);
    wr(4'h1, 8'h01);
    repeat (4) @(posedge clk);
    check({7'h00, irq_n}, 8'h01);
    wr(4'h1, 8'h11);
    wr(4'he, 8'h80);
    repeat (64) @(posedge clk);
    n0 = irq_falls;
    repeat (1920) @(posedge clk);
    near(irq_falls - n0, 10, 1);
    rd_chk(4'h1, 8'h15);
    wr(4'h1, 8'h10);
    repeat (600) @(posedge clk);
    check({7'h00, irq_n}, 8'h01);
    rd_chk(4'h1, 8'h14);
    wr(4'h1, 8'h11);
    wr(4'hf, 8'h01);
    wr(4'he, 8'h81);
    n0 = irq_falls;
    repeat (8192) @(posedge clk);
    near(irq_falls - n0, 2, 1);
    wr(4'he, 8'h00);
    wr(4'h6, 8'hff);
    rd_chk(4'h6, 8'h07);
    bus_go(4'h6, 1'b1, 8'h00, 4'he);
    rd_chk(4'h6, 8'h07);
    wr(4'h0, 8'h20);
    for (int k = 0; k < 7; k++) wr(4'(k + 2), tv[k]);
    wr(4'h9, 8'h00);
    for (int k = 10; k < 13; k++) wr(4'(k), 8'h80);
    wr(4'h1, 8'h02);
    bus_go(4'h2, 1'b0, 8'h00, 4'h1);
    check({rd_data[7], 7'h00}, 8'h00);
    wr(4'h0, 8'h00);
    repeat (1900) @(posedge clk);
    rd_chk(4'h2, 8'h59);
    n = 0;
    do begin
      bus_go(4'h2, 1'b0, 8'h00, 4'h1);
      n++;
    end while (rd_data === 8'h59 && n < 2000);
    for (int k = 0; k < 7; k++) rd_chk(4'(k + 2), te[k]);
    rd_chk(4'h1, 8'h0a);
    check({7'h00, irq_n}, 8'h00);
    wr(4'h1, 8'h00);
    repeat (4) @(posedge clk);
    check({7'h00, irq_n}, 8'h01);
    give_verdict();
  end
endmodule // tb_rtc_calendar_timer_alarm
`default_nettype wire
